// ==== rtl/flash_program_unlock_address.sv ====
// Unlock key, target address and operation launch for the program flash array
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: Unlock key register is write-only, resets to zero, every read returns zero.
// RULE_02: Flash operations launch only after a completed unlock sequence; stray writes refused.
// RULE_03: Target address register is 32-bit read/write, cleared to zero at reset.
// RULE_04: Bulk erase ignores the target address completely.
// RULE_05: Page erase acts on the page selected by the target address.
// RULE_06: Row programming acts on the row selected by the target address.
// RULE_07: Word programming acts on the word at the target address.
// RULE_08: Unlock keys are parameters; a wrong or out-of-order key restarts the sequence.
module flash_program_unlock_address #(
  // Arbitrary default keys; set per product
  parameter logic [31:0] UNLOCK_KEY_FIRST  = 32'h5A5A0001,
  parameter logic [31:0] UNLOCK_KEY_SECOND = 32'hA5A50002
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             FLASH_REQ,
  output logic [2:0]       FLASH_OP,
  output logic [31:0]      FLASH_ADDR,
  input  wire logic        FLASH_DONE
);

  typedef struct packed {
    logic                      aw_got;
    logic [7:0]                aw_addr;
    logic                      w_got;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      key_stage;
    logic                      unlocked;
    flash_unlock_pkg::flash_op_e op;
    logic [31:0]               target_addr;
    logic                      busy;
    logic                      err;
    flash_unlock_pkg::flash_op_e flash_op;
    logic [31:0]               flash_addr;
  } state_s;

  state_s      state_reg;
  state_s      state_next;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  wr_addr;
  logic [7:0]  rd_addr;
  logic        key_write;
  logic        start_write;

  localparam state_s STATE_RESET = '{
    aw_got: 1'b0, aw_addr: 8'h00, w_got: 1'b0, wdata: 32'h00000000, wstrb: 4'h0,
    bvalid: 1'b0, bresp: flash_unlock_pkg::RESP_OKAY, rvalid: 1'b0, rdata: 32'h00000000,
    rresp: flash_unlock_pkg::RESP_OKAY, key_stage: 1'b0, unlocked: 1'b0,
    op: flash_unlock_pkg::OP_NONE, target_addr: flash_unlock_pkg::ADDR_RESET, busy: 1'b0,
    err: 1'b0, flash_op: flash_unlock_pkg::OP_NONE, flash_addr: 32'h00000000};

  assign AWREADY     = !state_reg.aw_got && !state_reg.bvalid;
  assign WREADY      = !state_reg.w_got && !state_reg.bvalid;
  assign ARREADY     = !state_reg.rvalid;
  assign BVALID      = state_reg.bvalid;
  assign BRESP       = state_reg.bresp;
  assign RVALID      = state_reg.rvalid;
  assign RDATA       = state_reg.rdata;
  assign RRESP       = state_reg.rresp;
  assign FLASH_REQ   = state_reg.busy;
  assign FLASH_OP    = state_reg.flash_op;
  assign FLASH_ADDR  = state_reg.flash_addr;

  assign wr_fire     = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  assign rd_fire     = ARVALID && ARREADY;
  assign wr_addr     = {state_reg.aw_addr[7:2], 2'b00};
  assign rd_addr     = {ARADDR[7:2], 2'b00};
  assign key_write   = wr_fire && (wr_addr == flash_unlock_pkg::OFF_UNLOCK_KEY);
  assign start_write = wr_fire && (wr_addr == flash_unlock_pkg::OFF_CTRL) && state_reg.wstrb[1]
                       && state_reg.wdata[flash_unlock_pkg::CTRL_START_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;
    if (AWVALID && AWREADY) begin
      state_next.aw_got  = 1'b1;
      state_next.aw_addr = AWADDR[7:0];
    end
    if (WVALID && WREADY) begin
      state_next.w_got = 1'b1;
      state_next.wdata = WDATA;
      state_next.wstrb = WSTRB;
    end
    if (state_reg.bvalid && BREADY) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.busy && FLASH_DONE) begin
      state_next.busy = 1'b0;
    end
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got  = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp  = flash_unlock_pkg::RESP_OKAY;
      unique case (wr_addr)
        flash_unlock_pkg::OFF_CTRL: begin
          if (state_reg.wstrb[0]) begin
            state_next.op = flash_unlock_pkg::flash_op_e'(state_reg.wdata[2:0]);
          end
          // Clear first so that a same-cycle error sets it again
          if (state_reg.wstrb[2] && state_reg.wdata[flash_unlock_pkg::CTRL_ERR_BIT]) begin
            state_next.err = 1'b0;
          end
          if (start_write) begin
            // Unlock is spent by any start attempt, good or bad
            state_next.unlocked  = 1'b0;
            state_next.key_stage = 1'b0;
            if (state_reg.unlocked && !state_reg.busy && state_next.op != flash_unlock_pkg::OP_NONE
                && state_next.op <= flash_unlock_pkg::OP_BULK_ERASE) begin  // RULE_02
              state_next.busy     = 1'b1;
              state_next.flash_op = state_next.op;
              unique case (state_next.op)
                flash_unlock_pkg::OP_WORD_PROG:                                           // RULE_07
                  state_next.flash_addr = {state_reg.target_addr[31:flash_unlock_pkg::WORD_LSB],
                                           {flash_unlock_pkg::WORD_LSB{1'b0}}};
                flash_unlock_pkg::OP_ROW_PROG:                                            // RULE_06
                  state_next.flash_addr = {state_reg.target_addr[31:flash_unlock_pkg::ROW_LSB],
                                           {flash_unlock_pkg::ROW_LSB{1'b0}}};
                flash_unlock_pkg::OP_PAGE_ERASE:                                          // RULE_05
                  state_next.flash_addr = {state_reg.target_addr[31:flash_unlock_pkg::PAGE_LSB],
                                           {flash_unlock_pkg::PAGE_LSB{1'b0}}};
                default:
                  state_next.flash_addr = 32'h00000000;  // RULE_04
              endcase
            end else begin
              state_next.err = 1'b1;  // RULE_02
            end
          end
        end
        flash_unlock_pkg::OFF_UNLOCK_KEY: begin
          // Partial-lane writes never match a key
          if (state_reg.wstrb == 4'hF && !state_reg.key_stage && state_reg.wdata == UNLOCK_KEY_FIRST) begin
            state_next.key_stage = 1'b1;
            state_next.unlocked  = 1'b0;
          end else if (state_reg.wstrb == 4'hF && state_reg.key_stage
                       && state_reg.wdata == UNLOCK_KEY_SECOND) begin
            state_next.key_stage = 1'b0;
            state_next.unlocked  = 1'b1;
          end else begin
            state_next.key_stage = 1'b0;  // RULE_08
            state_next.unlocked  = 1'b0;  // RULE_08
          end
        end
        flash_unlock_pkg::OFF_TARGET_ADDR: begin
          for (int i = 0; i < 4; i++) begin
            if (state_reg.wstrb[i]) begin
              state_next.target_addr[8*i +: 8] = state_reg.wdata[8*i +: 8];  // RULE_03
            end
          end
        end
        default: state_next.bresp = flash_unlock_pkg::RESP_DECERR;
      endcase
    end
    if (state_reg.rvalid && RREADY) begin
      state_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = flash_unlock_pkg::RESP_OKAY;
      unique case (rd_addr)
        flash_unlock_pkg::OFF_CTRL:
          state_next.rdata = {13'h0000, state_reg.err, state_reg.unlocked, state_reg.busy, 13'h0000, state_reg.op};
        flash_unlock_pkg::OFF_UNLOCK_KEY:  state_next.rdata = flash_unlock_pkg::KEY_RESET;  // RULE_01
        flash_unlock_pkg::OFF_TARGET_ADDR: state_next.rdata = state_reg.target_addr;        // RULE_03
        default: begin
          state_next.rdata = 32'h00000000;
          state_next.rresp = flash_unlock_pkg::RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence key_first_ok;
    key_write && state_reg.wstrb == 4'hF && !state_reg.key_stage && state_reg.wdata == UNLOCK_KEY_FIRST;
  endsequence

  sequence key_second_ok;
    key_write && state_reg.wstrb == 4'hF && state_reg.key_stage && state_reg.wdata == UNLOCK_KEY_SECOND;
  endsequence

  sequence key_bad;
    key_write && !(state_reg.wstrb == 4'hF && ((!state_reg.key_stage && state_reg.wdata == UNLOCK_KEY_FIRST)
                   || (state_reg.key_stage && state_reg.wdata == UNLOCK_KEY_SECOND)));
  endsequence

  a_key_reads_zero: assert property (@(posedge CLK) disable iff (RST)  // RULE_01
    rd_fire && rd_addr == flash_unlock_pkg::OFF_UNLOCK_KEY |=> RVALID && RDATA == 32'h00000000)
    else $error("unlock key read returned nonzero");

  a_locked_start_err: assert property (@(posedge CLK) disable iff (RST)  // RULE_02
    start_write && !state_reg.unlocked |=> state_reg.err && $stable(FLASH_OP))
    else $error("locked start not refused");

  a_busy_start_err: assert property (@(posedge CLK) disable iff (RST)  // RULE_02
    start_write && state_reg.busy |=> state_reg.err && $stable(FLASH_OP) && $stable(FLASH_ADDR))
    else $error("busy start not refused");

  a_req_needs_unlock: assert property (@(posedge CLK) disable iff (RST)  // RULE_02
    $rose(FLASH_REQ) |-> $past(state_reg.unlocked) && !state_reg.unlocked)
    else $error("flash request without unlock");

  a_addr_write_back: assert property (@(posedge CLK) disable iff (RST)  // RULE_03
    wr_fire && wr_addr == flash_unlock_pkg::OFF_TARGET_ADDR && state_reg.wstrb == 4'hF
    |=> state_reg.target_addr == $past(state_reg.wdata))
    else $error("target address write lost");

  a_addr_read_back: assert property (@(posedge CLK) disable iff (RST)  // RULE_03
    rd_fire && rd_addr == flash_unlock_pkg::OFF_TARGET_ADDR && !wr_fire
    |=> RDATA == $past(state_reg.target_addr))
    else $error("target address readback wrong");

  a_bulk_addr_zero: assert property (@(posedge CLK) disable iff (RST)  // RULE_04
    FLASH_REQ && FLASH_OP == flash_unlock_pkg::OP_BULK_ERASE |-> FLASH_ADDR == 32'h00000000)
    else $error("bulk erase address not ignored");

  a_page_select: assert property (@(posedge CLK) disable iff (RST)  // RULE_05
    $rose(FLASH_REQ) && FLASH_OP == flash_unlock_pkg::OP_PAGE_ERASE
    |-> FLASH_ADDR[31:10] == state_reg.target_addr[31:10] && FLASH_ADDR[9:0] == 10'h000)
    else $error("page erase address wrong");

  a_row_select: assert property (@(posedge CLK) disable iff (RST)  // RULE_06
    $rose(FLASH_REQ) && FLASH_OP == flash_unlock_pkg::OP_ROW_PROG
    |-> FLASH_ADDR[31:7] == state_reg.target_addr[31:7] && FLASH_ADDR[6:0] == 7'h00)
    else $error("row program address wrong");

  a_word_select: assert property (@(posedge CLK) disable iff (RST)  // RULE_07
    $rose(FLASH_REQ) && FLASH_OP == flash_unlock_pkg::OP_WORD_PROG
    |-> FLASH_ADDR == {state_reg.target_addr[31:2], 2'b00})
    else $error("word program address wrong");

  a_unlock_pair: assert property (@(posedge CLK) disable iff (RST)  // RULE_08
    key_first_ok ##1 (!wr_fire) [*1] ##[0:20] key_second_ok |=> state_reg.unlocked)
    else $error("valid key pair did not unlock");

  a_bad_key_restart: assert property (@(posedge CLK) disable iff (RST)  // RULE_08
    key_bad |=> !state_reg.unlocked && !state_reg.key_stage)
    else $error("wrong key did not restart sequence");

endmodule

// ==== rtl/flash_unlock_pkg.sv ====
// Constants and types shared by the program flash unlock and address block
package flash_unlock_pkg;

  // Register byte offsets on the register bus
  localparam logic [7:0] OFF_CTRL         = 8'h00;
  localparam logic [7:0] OFF_UNLOCK_KEY   = 8'h04;
  localparam logic [7:0] OFF_TARGET_ADDR  = 8'h08;

  // Control register field positions
  localparam int         CTRL_OP_LSB      = 0;
  localparam int         CTRL_START_BIT   = 15;
  localparam int         CTRL_BUSY_BIT    = 16;
  localparam int         CTRL_UNLOCK_BIT  = 17;
  localparam int         CTRL_ERR_BIT     = 18;

  // Values after reset
  localparam logic [31:0] KEY_RESET       = 32'h00000000;
  localparam logic [31:0] ADDR_RESET      = 32'h00000000;

  // Alignment of the target address per operation (log2 of bytes)
  localparam int         WORD_LSB         = 2;
  localparam int         ROW_LSB          = 7;
  localparam int         PAGE_LSB         = 10;

  // Bus responses
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_DECERR      = 2'h3;

  typedef enum logic [2:0] {
    OP_NONE       = 3'b000,
    OP_WORD_PROG  = 3'b001,
    OP_ROW_PROG   = 3'b010,
    OP_PAGE_ERASE = 3'b011,
    OP_BULK_ERASE = 3'b100
  } flash_op_e;

endpackage

// ==== test/tb.sv ====
// Self-checking bench for the flash unlock and target address block
`timescale 1ns/1ns

module tb;
  logic        CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, FLASH_DONE;
  logic [31:0] AWADDR, WDATA, ARADDR, RDATA, FLASH_ADDR;
  logic [3:0]  WSTRB;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, FLASH_REQ;
  logic [1:0]  BRESP, RRESP;
  logic [2:0]  FLASH_OP;
  int          err_total, tests_run;
  // Arbitrary keys, deliberately not the defaults
  localparam logic [31:0] KEY1   = 32'h3C5A0F12;
  localparam logic [31:0] KEY2   = 32'hC3A5F0ED;
  localparam logic [31:0] A_CTRL = {24'h000000, flash_unlock_pkg::OFF_CTRL};
  localparam logic [31:0] A_KEY  = {24'h000000, flash_unlock_pkg::OFF_UNLOCK_KEY};
  localparam logic [31:0] A_ADDR = {24'h000000, flash_unlock_pkg::OFF_TARGET_ADDR};

  flash_program_unlock_address #(.UNLOCK_KEY_FIRST(KEY1), .UNLOCK_KEY_SECOND(KEY2)) DUT (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .FLASH_REQ(FLASH_REQ),
    .FLASH_OP(FLASH_OP), .FLASH_ADDR(FLASH_ADDR), .FLASH_DONE(FLASH_DONE));

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready sampled at the falling edge, acted on after the next rising edge
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_p, w_p, aw_t, w_t;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (aw_p || w_p) begin
      @(negedge CLK);
      aw_t = aw_p && (AWREADY === 1'b1);
      w_t = w_p && (WREADY === 1'b1);
      @(posedge CLK);
      if (aw_t) begin
        AWVALID <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_t) begin
        WVALID <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(negedge CLK); while (BVALID !== 1'b1);
    r = BRESP;
    @(posedge CLK);
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_p;
    ar_p = 1'b1;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(negedge CLK);
      if (RVALID !== 1'b1) begin
        if (ar_p && ARREADY === 1'b1) begin
          @(posedge CLK);
          ARVALID <= 1'b0;
          ar_p = 1'b0;
        end
      end
    end while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    @(posedge CLK);
    RREADY <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(A_KEY, d, r);
    chk("key reset", 32'h00000000, d);
    rd(A_ADDR, d, r);
    chk("addr reset", 32'h00000000, d);
    wr(A_ADDR, 32'hA5C31E77, 4'hF, r);
    chk("addr bresp", 32'h0, {30'h0, r});
    rd(A_ADDR, d, r);
    chk("addr readback", 32'hA5C31E77, d);
    chk("addr rresp", 32'h0, {30'h0, r});
    wr(A_ADDR, 32'h11223344, 4'h3, r);
    rd(A_ADDR, d, r);
    chk("addr lanes", 32'hA5C33344, d);
    wr(A_KEY, KEY1, 4'hF, r);
    rd(A_KEY, d, r);
    chk("key readback", 32'h00000000, d);
    wr(32'h00000010, 32'h12345678, 4'hF, r);
    chk("unmapped bresp", 32'h3, {30'h0, r});
    rd(32'h00000010, d, r);
    chk("unmapped rresp", 32'h3, {30'h0, r});
    $display("test regs done");
  endtask

  // Start refused when locked, and after a key sequence broken by a wrong key
  task automatic t_refuse(input bit broken);
    logic [31:0] d;
    logic [1:0]  r;
    if (broken) begin
      wr(A_KEY, KEY1, 4'hF, r);
      wr(A_KEY, 32'h00000001, 4'hF, r);
      wr(A_KEY, KEY2, 4'hF, r);
      rd(A_CTRL, d, r);
      chk("unlocked bit", 32'h0, {31'h0, d[flash_unlock_pkg::CTRL_UNLOCK_BIT]});
    end
    wr(A_CTRL, 32'h00008001, 4'hF, r);
    @(negedge CLK);
    chk("refused req", 32'h0, {31'h0, FLASH_REQ});
    rd(A_CTRL, d, r);
    chk("error bit", 32'h1, {31'h0, d[flash_unlock_pkg::CTRL_ERR_BIT]});
    wr(A_CTRL, 32'h00040000, 4'h4, r);
    rd(A_CTRL, d, r);
    chk("error cleared", 32'h0, {31'h0, d[flash_unlock_pkg::CTRL_ERR_BIT]});
    $display("test refuse done");
  endtask

  task automatic t_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] exp);
    logic [1:0] r;
    // Address write between the keys must not break the sequence
    wr(A_KEY, KEY1, 4'hF, r);
    wr(A_ADDR, a, 4'hF, r);
    wr(A_KEY, KEY2, 4'hF, r);
    wr(A_CTRL, {29'h00001000, op}, 4'hF, r);
    @(negedge CLK);
    chk("req", 32'h1, {31'h0, FLASH_REQ});
    chk("op", {29'h0, op}, {29'h0, FLASH_OP});
    chk("flash addr", exp, FLASH_ADDR);
    @(posedge CLK);
    FLASH_DONE <= 1'b1;
    @(posedge CLK);
    FLASH_DONE <= 1'b0;
    @(negedge CLK);
    chk("req after done", 32'h0, {31'h0, FLASH_REQ});
    $display("test op %0d done", op);
  endtask

  // Start refused while busy, and with an unknown operation code
  task automatic t_busy;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_KEY, KEY1, 4'hF, r);
    wr(A_KEY, KEY2, 4'hF, r);
    wr(A_ADDR, 32'h00002468, 4'hF, r);
    wr(A_CTRL, 32'h00008002, 4'hF, r);
    wr(A_KEY, KEY1, 4'hF, r);
    wr(A_KEY, KEY2, 4'hF, r);
    wr(A_CTRL, 32'h00008003, 4'hF, r);
    @(negedge CLK);
    chk("busy req", 32'h1, {31'h0, FLASH_REQ});
    chk("busy op", 32'h2, {29'h0, FLASH_OP});
    chk("busy addr", 32'h00002400, FLASH_ADDR);
    rd(A_CTRL, d, r);
    chk("busy bit", 32'h1, {31'h0, d[flash_unlock_pkg::CTRL_BUSY_BIT]});
    chk("busy err", 32'h1, {31'h0, d[flash_unlock_pkg::CTRL_ERR_BIT]});
    @(posedge CLK);
    FLASH_DONE <= 1'b1;
    @(posedge CLK);
    FLASH_DONE <= 1'b0;
    wr(A_CTRL, 32'h00040000, 4'h4, r);
    wr(A_KEY, KEY1, 4'hF, r);
    wr(A_KEY, KEY2, 4'hF, r);
    wr(A_CTRL, 32'h00008005, 4'hF, r);
    @(negedge CLK);
    chk("bad op req", 32'h0, {31'h0, FLASH_REQ});
    rd(A_CTRL, d, r);
    chk("bad op err", 32'h1, {31'h0, d[flash_unlock_pkg::CTRL_ERR_BIT]});
    chk("unlock spent", 32'h0, {31'h0, d[flash_unlock_pkg::CTRL_UNLOCK_BIT]});
    wr(A_CTRL, 32'h00040000, 4'h4, r);
    $display("test busy done");
  endtask

  // Reset in mid-run with an operation running and the address set
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    wr(A_KEY, KEY1, 4'hF, r);
    wr(A_KEY, KEY2, 4'hF, r);
    wr(A_ADDR, 32'h13572468, 4'hF, r);
    wr(A_CTRL, 32'h00008001, 4'hF, r);
    @(posedge CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    chk("req after reset", 32'h0, {31'h0, FLASH_REQ});
    rd(A_ADDR, d, r);
    chk("addr after reset", 32'h0, d);
    rd(A_CTRL, d, r);
    chk("ctrl after reset", 32'h0, d);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    err_total = 0;
    tests_run = 0;
    {RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, FLASH_DONE} = 7'h7F & 7'h40;
    {AWADDR, WDATA, ARADDR, WSTRB} = 100'h0;
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_refuse(1'b0);
    t_refuse(1'b1);
    t_op(flash_unlock_pkg::OP_WORD_PROG, 32'h12345677, 32'h12345674);
    t_op(flash_unlock_pkg::OP_ROW_PROG, 32'h123456FF, 32'h12345680);
    t_op(flash_unlock_pkg::OP_PAGE_ERASE, 32'h12345FFF, 32'h12345C00);
    t_op(flash_unlock_pkg::OP_BULK_ERASE, 32'hFFFFFFFF, 32'h00000000);
    t_busy();
    t_reset();
    test_done();
  end
endmodule
